// ==== hdl/cfm_i2c_slave.sv ====
// Two-wire slave port that turns bus transfers into register strobes.
`timescale 1ns/100ps
module cfm_i2c_slave (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset_n,
  // Bus pins
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe,
  // Register access
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata,
  input wire logic [7:0] i_rdata
);
  import cfm_pkg::*;

  typedef struct packed {
    logic scl1, scl2, scl3, sda1, sda2, sda3;
    cfm_i2c_st_t st;
    logic [3:0] bitn;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic [7:0] wdata;
    logic rw, got_reg, pend, sda_oe, wr, rd;
  } cfm_i2c_q_t;

  cfm_i2c_q_t q, d;
  logic scl_rise, scl_fall, start, stop;

  always_comb begin
    d = q;
    d.scl1 = i_scl;
    d.scl2 = q.scl1;
    d.scl3 = q.scl2;
    d.sda1 = i_sda;
    d.sda2 = q.sda1;
    d.sda3 = q.sda2;
    d.wr = 1'b0;
    d.rd = 1'b0;
    d.pend = q.rd;
    scl_rise = q.scl2 & ~q.scl3;
    scl_fall = ~q.scl2 & q.scl3;
    start = q.scl2 & q.scl3 & q.sda3 & ~q.sda2;
    stop = q.scl2 & q.scl3 & ~q.sda3 & q.sda2;
    // The pointer steps after each access so bursts walk the map.
    if (q.wr) begin
      d.ptr = q.ptr + 8'h01;
    end
    if (q.pend) begin
      d.shift = i_rdata;
      d.sda_oe = ~i_rdata[7];
      d.ptr = q.ptr + 8'h01;
    end
    if (start) begin
      d.st = I2_DEV;
      d.bitn = 4'h0;
      d.sda_oe = 1'b0;
      d.got_reg = 1'b0;
    end else if (stop) begin
      d.st = I2_IDLE;
      d.sda_oe = 1'b0;
    end else if (scl_rise) begin
      unique case (q.st)
        I2_DEV, I2_REG, I2_WDAT: begin
          d.shift = {q.shift[6:0], q.sda2};
          d.bitn = q.bitn + 4'h1;
        end
        I2_TACK: begin
          if (q.sda2) begin
            d.st = I2_IDLE;
          end
        end
        I2_IDLE, I2_ACK, I2_TX: begin
        end
      endcase
    end else if (scl_fall) begin
      unique case (q.st)
        I2_DEV: begin
          if (q.bitn == 4'h8) begin
            if (q.shift[7:1] == I2C_DEV_ADDR) begin
              d.sda_oe = 1'b1;
              d.rw = q.shift[0];
              d.st = I2_ACK;
            end else begin
              d.st = I2_IDLE;
            end
          end
        end
        I2_REG: begin
          if (q.bitn == 4'h8) begin
            d.ptr = q.shift;
            d.got_reg = 1'b1;
            d.sda_oe = 1'b1;
            d.st = I2_ACK;
          end
        end
        I2_WDAT: begin
          if (q.bitn == 4'h8) begin
            d.wr = 1'b1;
            d.wdata = q.shift;
            d.sda_oe = 1'b1;
            d.st = I2_ACK;
          end
        end
        I2_ACK: begin
          d.sda_oe = 1'b0;
          d.bitn = 4'h0;
          if (q.rw) begin
            d.rd = 1'b1;
            d.st = I2_TX;
          end else begin
            d.st = q.got_reg ? I2_WDAT : I2_REG;
          end
        end
        I2_TX: begin
          d.bitn = q.bitn + 4'h1;
          if (q.bitn == 4'h7) begin
            d.sda_oe = 1'b0;
            d.st = I2_TACK;
          end else begin
            d.shift = {q.shift[6:0], 1'b0};
            d.sda_oe = ~q.shift[6];
          end
        end
        I2_TACK: begin
          d.rd = 1'b1;
          d.bitn = 4'h0;
          d.st = I2_TX;
        end
        I2_IDLE: begin
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      q <= '{scl1: 1'b1, scl2: 1'b1, scl3: 1'b1, sda1: 1'b1, sda2: 1'b1,
             sda3: 1'b1, st: I2_IDLE, default: '0};
    end else begin
      q <= d;
    end
  end

  assign o_sda_o = 1'b0;
  assign o_sda_oe = q.sda_oe;
  assign o_wr = q.wr;
  assign o_rd = q.rd;
  assign o_addr = q.ptr;
  assign o_wdata = q.wdata;
endmodule

// ==== hdl/cfm_monitor.sv ====
// Status, protection and host notification logic of the charger.
//
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/100ps
module cfm_monitor #(
  parameter logic [cfm_pkg::CNT_W-1:0] IRQ_CYC = cfm_pkg::IRQ_PULSE_CYC,
  parameter logic [cfm_pkg::CNT_W-1:0] BLINK_CYC = cfm_pkg::BLINK_HALF_CYC,
  parameter logic [cfm_pkg::CNT_W-1:0] SHIP_CYC = cfm_pkg::SHIP_DEGLITCH_CYC
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset_n,
  // Register port
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  // Two-wire bus pins
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe,
  // Analog comparator flags and push button
  input wire logic [cfm_pkg::SENSE_W-1:0] i_sense,
  input wire logic i_push_button_n,
  // Power stage controls
  output logic o_switching_en,
  output logic o_charge_en,
  output logic o_boost_en,
  output logic o_battery_switch_on,
  output logic o_warm_charge_voltage_target_4v1,
  output logic [1:0] o_charge_scale,
  output logic [1:0] o_precharge_mode,
  output logic o_term_en,
  output logic o_timer_half,
  output logic o_thermal_fold,
  // Indicator pins
  output logic o_input_good_n,
  output logic o_stat_o,
  output logic o_stat_oe,
  output logic o_host_irq_n
);
  import cfm_pkg::*;

  typedef struct packed {
    logic [SENSE_W-1:0] s1, s2, s3;
    logic pb1, pb2;
    logic [12:0][7:0] regs;
    logic [7:0] rdata, fault_latch, fault_prev;
    logic fault_hold, fault_read, boost_fault, shut, ocp_off, dpl_off;
    logic [2:0] retry;
    logic [CNT_W-1:0] pb_cnt, blink_cnt, irq_cnt;
    logic pb_fired, blink_ph;
    logic sw_en, chg_en, bst_en, bat_sw, warm41, term_en, tmr_half, fold;
    logic [1:0] scale, pre;
    logic pg_n, stat_o, stat_oe, irq_n;
  } cfm_mon_q_t;

  cfm_mon_q_t q, d;
  logic i2c_wr, i2c_rd;
  logic [7:0] i2c_addr, i2c_wdata;
  logic wr, rd, mapped, pb_fire, ship_exit, fread, fault_evt, irq_evt;
  logic ts_out, bst_ts_out, boost_req, chg_req, pg, thermal_limit_select, fail;
  logic boost_run, conv_ok, charging, suspend;
  logic [7:0] addr, wdata, live, status;
  logic [SENSE_W-1:0] s, rise, fall;

  cfm_i2c_slave u_i2c (
    .i_mclk(i_mclk),
    .i_reset_n(i_reset_n),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .o_sda_o(o_sda_o),
    .o_sda_oe(o_sda_oe),
    .o_wr(i2c_wr),
    .o_rd(i2c_rd),
    .o_addr(i2c_addr),
    .o_wdata(i2c_wdata),
    .i_rdata(q.rdata)
  );

  always_comb begin
    d = q;
    d.s1 = i_sense;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.pb1 = i_push_button_n;
    d.pb2 = q.pb1;
    s = q.s2;
    rise = q.s2 & ~q.s3;
    fall = ~q.s2 & q.s3;
    // The plain port wins a collision; the clashing bus access is lost.
    wr = i_reg_wr | (i2c_wr & ~i_reg_rd);
    rd = i_reg_rd | (i2c_rd & ~i_reg_wr);
    addr = (i_reg_wr | i_reg_rd) ? i_reg_addr : i2c_addr;
    wdata = i_reg_wr ? i_reg_wdata : i2c_wdata;
    mapped = addr <= REG_LAST;
    ts_out = s[S_TS_COLD] | s[S_TS_HOT];
    bst_ts_out = s[S_BST_COLD] | s[S_BST_HOT];
    boost_req = q.regs[REG_CTRL1][B_BOOST_EN];
    chg_req = q.regs[REG_CTRL1][B_CHG_EN] & ~boost_req;
    pg = s[S_POOR_OK] & s[S_SRC_DONE] & s[S_VBUS_IN];
    thermal_limit_select = q.regs[REG_TEMP][B_THERMAL_LIMIT_SELECT] ? s[S_DIE_90] : s[S_DIE_110];
    d.shut = s[S_DIE_SHUT] | (q.shut & ~s[S_DIE_HYS]);
    if (wr && mapped && addr != REG_STATUS && addr != REG_FAULT) begin
      d.regs[addr[3:0]] = wdata;
    end
    if (wr && addr == REG_CTRL1 && wdata[B_BOOST_EN]) begin
      d.boost_fault = 1'b0;
      d.retry = 3'h0;
    end
    // Push button must stay low for the whole deglitch time.
    pb_fire = 1'b0;
    if (q.pb2) begin
      d.pb_cnt = '0;
      d.pb_fired = 1'b0;
    end else if (!q.pb_fired) begin
      if (q.pb_cnt == SHIP_CYC - 1'b1) begin
        pb_fire = 1'b1;
        d.pb_fired = 1'b1;
      end else begin
        d.pb_cnt = q.pb_cnt + 1'b1;
      end
    end
    ship_exit = pb_fire | rise[S_VBUS_IN] | (wr && addr == REG_SWITCH &&
      q.regs[REG_SWITCH][B_BATSW_DIS] && !wdata[B_BATSW_DIS]);
    if (pb_fire) begin
      d.regs[REG_SWITCH][B_BATSW_DIS] = 1'b0;
    end
    d.ocp_off = (q.ocp_off & ~ship_exit) | s[S_BAT_OCP];
    d.dpl_off = (q.dpl_off | s[S_BAT_DPL]) & ~s[S_VBUS_IN];
    fail = 1'b0;
    if (boost_req && rise[S_BST_SHORT]) begin
      if (q.retry == BOOST_RETRIES) begin
        fail = 1'b1;
      end else begin
        d.retry = q.retry + 3'h1;
      end
    end
    // Hardware disables boost after the host write, so safety wins.
    if (fail || (boost_req && (s[S_BST_OV] || s[S_DIE_SHUT]))) begin
      d.regs[REG_CTRL1][B_BOOST_EN] = 1'b0;
      d.boost_fault = 1'b1;
    end
    live = 8'h00;
    live[B_F_BOOST] = d.boost_fault;
    live[B_F_BAT] = s[S_BAT_OV];
    if (s[S_VBUS_IN] && !boost_req) begin
      if (s[S_VBUS_OV]) begin
        live[B_F_CHG +: 2] = CF_INPUT;
      end else if (d.shut) begin
        live[B_F_CHG +: 2] = CF_THERMAL;
      end else if (s[S_TMR_FAULT]) begin
        live[B_F_CHG +: 2] = CF_TIMER;
      end
    end
    if ((boost_req || s[S_VBUS_IN]) && (boost_req ? bst_ts_out : ts_out)) begin
      live[B_F_NTC +: 3] = (s[S_BST_COLD] | s[S_TS_COLD]) ? NTC_COLD
                                                           : NTC_HOT;
    end
    fread = rd && addr == REG_FAULT;
    d.fault_latch = fread ? live : (q.fault_latch | live);
    d.fault_prev = live;
    fault_evt = (|(live & ~q.fault_prev)) & ~q.fault_hold;
    d.fault_read = q.fault_read | fread;
    if (fault_evt) begin
      d.fault_hold = 1'b1;
    end else if (q.fault_hold && d.fault_read && live == 8'h00) begin
      d.fault_hold = 1'b0;
      d.fault_read = 1'b0;
    end
    status = 8'h00;
    if (pg && !(boost_req && bst_ts_out)) begin
      status[B_SRC_STAT +: 3] = s[S_SRC_TYPE +: 3];
    end
    status[B_PG] = pg;
    status[B_THERM] = thermal_limit_select;
    d.rdata = 8'h00;
    if (rd && mapped) begin
      if (addr == REG_FAULT) begin
        d.rdata = q.fault_latch;
      end else if (addr == REG_STATUS) begin
        d.rdata = status;
      end else begin
        d.rdata = q.regs[addr[3:0]];
      end
    end
    conv_ok = ~s[S_VBUS_OV] & ~s[S_SYS_OV] & ~d.shut;
    boost_run = d.regs[REG_CTRL1][B_BOOST_EN] & ~bst_ts_out &
      ~s[S_BST_SHORT] & conv_ok;
    charging = chg_req & pg & ~ts_out & ~s[S_BAT_OV] & ~s[S_TMR_FAULT] &
      ~s[S_CHG_DONE] & conv_ok;
    d.sw_en = boost_run | (pg & ~boost_req & conv_ok);
    d.chg_en = charging;
    d.bst_en = boost_run;
    d.bat_sw = ~d.regs[REG_SWITCH][B_BATSW_DIS] & ~d.ocp_off & ~d.dpl_off &
      ~d.shut;
    d.warm41 = s[S_TS_WARM] & q.regs[REG_TEMP][B_WARM_VSET];
    d.scale = SCALE_FULL;
    if (s[S_TS_COOL]) begin
      d.scale = q.regs[REG_TEMP][B_COOL_ISET] ? SCALE_20PCT
                                                : SCALE_HALF;
    end
    d.pre = s[S_BAT_SHORT] ? PRE_SHORT
          : (s[S_BAT_LOWV] ? PRE_PRECHG : PRE_NORMAL);
    d.term_en = ~thermal_limit_select;
    d.fold = thermal_limit_select;
    d.tmr_half = q.regs[REG_TEMP][B_TMR2X] &
      (s[S_VLIM] | s[S_ILIM] | s[S_TS_COOL] | thermal_limit_select);
    d.pg_n = ~pg;
    suspend = (chg_req & s[S_VBUS_IN] & (s[S_VBUS_OV] | ts_out |
      s[S_TMR_FAULT] | s[S_SYS_OV])) | (boost_req & bst_ts_out);
    if (!suspend) begin
      d.blink_cnt = '0;
      d.blink_ph = 1'b0;
    end else if (q.blink_cnt == BLINK_CYC - 1'b1) begin
      d.blink_cnt = '0;
      d.blink_ph = ~q.blink_ph;
    end else begin
      d.blink_cnt = q.blink_cnt + 1'b1;
    end
    d.stat_o = 1'b0;
    d.stat_oe = (q.regs[REG_CTRL0][B_STAT_CFG +: 2] == STAT_ON) &&
      (suspend ? !q.blink_ph : charging);
    irq_evt = rise[S_SRC_DONE] | rise[S_POOR_OK] | fall[S_VBUS_IN] |
      rise[S_CHG_DONE] | fault_evt |
      (rise[S_VLIM] & ~q.regs[REG_MASK][B_VLIM_MASK]) |
      (rise[S_ILIM] & ~q.regs[REG_MASK][B_ILIM_MASK]);
    // Events during a pulse merge into it rather than stretch it.
    if (!q.irq_n) begin
      if (q.irq_cnt == '0) begin
        d.irq_n = 1'b1;
      end else begin
        d.irq_cnt = q.irq_cnt - 1'b1;
      end
    end else if (irq_evt) begin
      d.irq_n = 1'b0;
      d.irq_cnt = IRQ_CYC - 1'b1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      q <= '{pb1: 1'b1, pb2: 1'b1, regs: REGS_RST, term_en: 1'b1,
             pg_n: 1'b1, irq_n: 1'b1, default: '0};
    end else begin
      q <= d;
    end
  end

  assign o_reg_rdata = q.rdata;
  assign o_switching_en = q.sw_en;
  assign o_charge_en = q.chg_en;
  assign o_boost_en = q.bst_en;
  assign o_battery_switch_on = q.bat_sw;
  assign o_warm_charge_voltage_target_4v1 = q.warm41;
  assign o_charge_scale = q.scale;
  assign o_precharge_mode = q.pre;
  assign o_term_en = q.term_en;
  assign o_timer_half = q.tmr_half;
  assign o_thermal_fold = q.fold;
  assign o_input_good_n = q.pg_n;
  assign o_stat_o = q.stat_o;
  assign o_stat_oe = q.stat_oe;
  assign o_host_irq_n = q.irq_n;

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_reset_n);

  chk_irq_start: assert property ($fell(q.irq_n) |->
    q.irq_cnt == IRQ_CYC - 1) else $error("irq pulse started wrong");
  chk_irq_end: assert property (!q.irq_n && q.irq_cnt == '0
    |=> q.irq_n) else $error("irq pulse did not end");
  chk_stat_off: assert property (q.regs[REG_CTRL0][6:5] == STAT_OFF
    |=> !q.stat_oe) else $error("indicator driven while disabled");
  chk_fault_first: assert property (fread |=>
    q.rdata == $past(q.fault_latch)) else $error("fault read not latched");
  chk_input_ovp: assert property (q.s2[S_VBUS_OV]
    |=> !q.sw_en) else $error("switching on input overvoltage");
  chk_sys_ovp: assert property (q.s2[S_SYS_OV]
    |=> !q.sw_en && !q.bst_en) else $error("converter on system ovp");
  chk_bat_ovp: assert property (q.s2[S_BAT_OV]
    |=> !q.chg_en) else $error("charging on battery overvoltage");
  chk_boost_ntc: assert property (q.s2[S_BST_HOT]
    |=> !q.bst_en) else $error("boost on thermistor fault");
  chk_ocp_latch: assert property (q.ocp_off |-> !q.bat_sw)
    else $error("battery switch on while latched off");
  chk_good_cause: assert property (!q.pg_n |->
    $past(q.s2[S_POOR_OK] && q.s2[S_SRC_DONE])) else $error("pg early");
  chk_shut_off: assert property (q.shut |-> !q.bat_sw && !q.sw_en)
    else $error("power path on in shutdown");
  chk_ts_window: assert property (ts_out
    |=> !q.chg_en) else $error("charging outside sensor window");
  chk_warm_charge_voltage_target: assert property (q.s2[S_TS_WARM] &&
    q.regs[REG_TEMP][B_WARM_VSET] |=> q.warm41)
    else $error("warm band voltage not reduced");
  chk_stat_charge: assert property (!suspend && charging &&
    q.regs[REG_CTRL0][6:5] == STAT_ON |=> q.stat_oe)
    else $error("indicator not low while charging");
  chk_boost_ovp: assert property (boost_req &&
    q.s2[S_BST_OV] |=> !boost_req && q.boost_fault)
    else $error("boost not stopped on overvoltage");
  chk_thermal_limit_select_fold: assert property (thermal_limit_select
    |=> q.fold && !q.term_en) else $error("thermal regulation missed");
  chk_dpl_open: assert property (q.dpl_off |-> !q.bat_sw)
    else $error("battery switch on while depleted");
endmodule

// ==== hdl/cfm_pkg.sv ====
// Shared constants and types of the charger fault and status monitor.
package cfm_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int CNT_W = 27;
  localparam int IRQ_PULSE_US = 256;
  localparam int BLINK_HALF_MS = 500;
  localparam int SHIP_DEGLITCH_MS = 1150;
  localparam logic [CNT_W-1:0] IRQ_PULSE_CYC =
    CNT_W'(IRQ_PULSE_US * (CLK_HZ / 1_000_000));
  localparam logic [CNT_W-1:0] BLINK_HALF_CYC =
    CNT_W'(BLINK_HALF_MS * (CLK_HZ / 1000));
  localparam logic [CNT_W-1:0] SHIP_DEGLITCH_CYC =
    CNT_W'(SHIP_DEGLITCH_MS * (CLK_HZ / 1000));
  localparam logic [2:0] BOOST_RETRIES = 3'h7;
  // Seven-bit form of the write address d6h.
  localparam logic [6:0] I2C_DEV_ADDR = 7'h6b;
  // Register offsets.
  localparam logic [7:0] REG_CTRL0 = 8'h00;
  localparam logic [7:0] REG_CTRL1 = 8'h01;
  localparam logic [7:0] REG_TEMP = 8'h06;
  localparam logic [7:0] REG_SWITCH = 8'h07;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_FAULT = 8'h09;
  localparam logic [7:0] REG_MASK = 8'h0a;
  localparam logic [7:0] REG_LAST = 8'h0c;
  localparam logic [12:0][7:0] REGS_RST = {8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h1a, 8'h17};
  // Field positions.
  localparam int B_STAT_CFG = 5;
  localparam int B_BOOST_EN = 5;
  localparam int B_CHG_EN = 4;
  localparam int B_TMR2X = 0;
  localparam int B_THERMAL_LIMIT_SELECT = 1;
  localparam int B_WARM_VSET = 2;
  localparam int B_COOL_ISET = 3;
  localparam int B_BATSW_DIS = 5;
  localparam int B_ILIM_MASK = 0;
  localparam int B_VLIM_MASK = 1;
  localparam int B_SRC_STAT = 5;
  localparam int B_PG = 2;
  localparam int B_THERM = 1;
  localparam int B_F_BOOST = 6;
  localparam int B_F_CHG = 4;
  localparam int B_F_BAT = 3;
  localparam int B_F_NTC = 0;
  localparam logic [1:0] STAT_ON = 2'h0;
  localparam logic [1:0] STAT_OFF = 2'h3;
  localparam logic [1:0] CF_INPUT = 2'h1;
  localparam logic [1:0] CF_THERMAL = 2'h2;
  localparam logic [1:0] CF_TIMER = 2'h3;
  localparam logic [2:0] NTC_COLD = 3'h5;
  localparam logic [2:0] NTC_HOT = 3'h6;
  localparam logic [1:0] SCALE_FULL = 2'h0;
  localparam logic [1:0] SCALE_HALF = 2'h1;
  localparam logic [1:0] SCALE_20PCT = 2'h2;
  localparam logic [1:0] PRE_NORMAL = 2'h0;
  localparam logic [1:0] PRE_SHORT = 2'h1;
  localparam logic [1:0] PRE_PRECHG = 2'h2;
  // Bit index of each analog comparator flag on the sense bus.
  localparam int S_TS_COLD = 0, S_TS_HOT = 1, S_TS_COOL = 2, S_TS_WARM = 3;
  localparam int S_BST_COLD = 4, S_BST_HOT = 5, S_VBUS_OV = 6;
  localparam int S_SYS_OV = 7, S_BAT_OV = 8, S_BST_SHORT = 9;
  localparam int S_BST_OV = 10, S_DIE_110 = 11, S_DIE_90 = 12;
  localparam int S_DIE_SHUT = 13, S_DIE_HYS = 14, S_BAT_DPL = 15;
  localparam int S_BAT_SHORT = 16, S_BAT_LOWV = 17, S_BAT_OCP = 18;
  localparam int S_POOR_OK = 19, S_SRC_DONE = 20, S_VBUS_IN = 21;
  localparam int S_VLIM = 22, S_ILIM = 23, S_CHG_DONE = 24;
  localparam int S_TMR_FAULT = 25, S_SRC_TYPE = 26, SENSE_W = 29;
  typedef enum logic [6:0] {
    I2_IDLE = 7'h01, I2_DEV = 7'h02, I2_REG = 7'h04, I2_WDAT = 7'h08,
    I2_ACK = 7'h10, I2_TX = 7'h20, I2_TACK = 7'h40
  } cfm_i2c_st_t;
endpackage

// ==== tb/cfm_i2c_host.sv ====
// Two-wire bus master model that plays the host controller.
`timescale 1ns/100ps
module cfm_i2c_host (
  // Bus pins
  output logic o_scl,
  output logic o_sda_low,
  input wire logic i_sda
);
  // The clock line stands high between frames, 80 ns per bit inside them.
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end

  task automatic put_bit(input logic b);
    o_sda_low = !b;
    #20;
    o_scl = 1'b1;
    #40;
    o_scl = 1'b0;
    #20;
  endtask

  // The data line is released for the acknowledge so the pull-up shows.
  task automatic put_byte(input logic [7:0] b, inout logic ack);
    for (int i = 7; i >= 0; i--) begin
      put_bit(b[i]);
    end
    o_sda_low = 1'b0;
    #20;
    o_scl = 1'b1;
    #20;
    ack = ack & !i_sda;
    #20;
    o_scl = 1'b0;
    #20;
  endtask

  task automatic write_reg(input logic [7:0] a, input logic [7:0] d,
                           output logic ack);
    ack = 1'b1;
    o_sda_low = 1'b1;
    #40;
    o_scl = 1'b0;
    #20;
    put_byte(8'hd6, ack);
    put_byte(a, ack);
    put_byte(d, ack);
    o_sda_low = 1'b1;
    #20;
    o_scl = 1'b1;
    #40;
    o_sda_low = 1'b0;
    #40;
  endtask
endmodule

// ==== tb/tb_charger_fault_status_monitor.sv ====
// Self-checking bench of the charger status and fault monitor.
`timescale 1ns/100ps
module tb_charger_fault_status_monitor;
  import cfm_pkg::*;
  typedef struct packed {
    logic [SENSE_W-1:0] s;
    logic [7:0] m;
    logic [7:0] e;
  } cfm_row_t;
  logic i_mclk = 1'b0;
  logic i_reset_n = 1'b0;
  logic [7:0] i_reg_addr = 8'h00;
  logic [7:0] i_reg_wdata = 8'h00;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic [SENSE_W-1:0] i_sense = '0;
  logic [7:0] o_reg_rdata, obs, d;
  logic o_sda_oe, o_switching_en, o_charge_en, o_warm_charge_voltage_target_4v1;
  logic o_term_en, o_timer_half, o_thermal_fold, o_input_good_n;
  logic o_stat_oe, o_host_irq_n, scl, host_low, ack;
  logic [1:0] o_charge_scale, o_precharge_mode;
  logic o_battery_switch_on, o_boost_en;
  logic pb_n = 1'b1;
  logic [SENSE_W-1:0] g;
  int n_mismatch = 0;
  int cmp_count = 0;
  cfm_row_t rows [7];
  wire sda = !(host_low | o_sda_oe);

  always #5 i_mclk = !i_mclk;
  assign obs = {o_input_good_n, o_charge_en, o_warm_charge_voltage_target_4v1,
    o_charge_scale, o_thermal_fold, o_term_en, o_timer_half};

  cfm_monitor #(.IRQ_CYC(CNT_W'(16)), .BLINK_CYC(CNT_W'(20)),
    .SHIP_CYC(CNT_W'(30))) u_dut (
    .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata), .i_scl(scl), .i_sda(sda), .o_sda_o(),
    .o_sda_oe(o_sda_oe), .i_sense(i_sense), .i_push_button_n(pb_n),
    .o_switching_en(o_switching_en), .o_charge_en(o_charge_en),
    .o_boost_en(o_boost_en), .o_battery_switch_on(o_battery_switch_on),
    .o_warm_charge_voltage_target_4v1(o_warm_charge_voltage_target_4v1), .o_charge_scale(o_charge_scale),
    .o_precharge_mode(o_precharge_mode), .o_term_en(o_term_en),
    .o_timer_half(o_timer_half), .o_thermal_fold(o_thermal_fold),
    .o_input_good_n(o_input_good_n), .o_stat_o(),
    .o_stat_oe(o_stat_oe), .o_host_irq_n(o_host_irq_n));

  cfm_i2c_host u_host (.o_scl(scl), .o_sda_low(host_low), .i_sda(sda));

  function automatic logic [SENSE_W-1:0] sb(input int i);
    return SENSE_W'(1) << i;
  endfunction

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] v);
    cmp_count++;
    if (v !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, v);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] w);
    @(posedge i_mclk);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= w;
    @(posedge i_mclk);
    i_reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge i_mclk);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_mclk);
    i_reg_rd <= 1'b0;
    #1;
    v = o_reg_rdata;
  endtask

  // Counts cycles with the interrupt low, or with the indicator pulled low.
  task automatic cnt(input int n, input bit sel, output logic [7:0] c);
    c = 8'h00;
    repeat (n) begin
      @(posedge i_mclk);
      #1;
      if ((sel ? o_stat_oe : !o_host_irq_n) === 1'b1) c++;
    end
  endtask

  task automatic put(input logic [SENSE_W-1:0] s, input int n);
    @(posedge i_mclk);
    i_sense <= s;
    repeat (n) @(posedge i_mclk);
  endtask

  // Holds the push button low for n cycles, then lets it settle high.
  task automatic press(input int n);
    @(posedge i_mclk);
    pb_n <= 1'b0;
    repeat (n) @(posedge i_mclk);
    pb_n <= 1'b1;
    repeat (4) @(posedge i_mclk);
  endtask

  task automatic print_verdict;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    #300us;
    n_mismatch++;
    print_verdict;
  end

  initial begin
    g = sb(S_VBUS_IN) | sb(S_POOR_OK) | sb(S_SRC_DONE);
    rows = '{'{g, 8'h80, 8'h00},
      '{sb(S_VBUS_IN) | sb(S_POOR_OK), 8'h80, 8'h80},
      '{g | sb(S_TS_COLD), 8'h40, 8'h00},
      '{g | sb(S_TS_WARM), 8'h20, 8'h20},
      '{g | sb(S_TS_COOL), 8'h18, 8'h10},
      '{g | sb(S_DIE_110), 8'h07, 8'h05},
      '{g | sb(S_VLIM), 8'h01, 8'h01}};
    repeat (2) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    repeat (3) @(posedge i_mclk);
    // Warm 4.1V, cool 20 percent and timer doubling go in over the bus.
    u_host.write_reg(REG_TEMP, 8'h0d, ack);
    chk("i2c_ack", 8'h01, {7'h0, ack});
    rd(REG_TEMP, d);
    chk("reg06", 8'h0d, d);
    foreach (rows[i]) begin
      put(rows[i].s, 8);
      chk("row", rows[i].e, obs & rows[i].m);
    end
    put(g, 30);
    rd(REG_FAULT, d);
    rd(REG_FAULT, d);
    put(g | sb(S_VBUS_OV), 0);
    cnt(30, 0, d);
    chk("irq_len", 8'h10, d);
    chk("switching", 8'h00, {7'h0, o_switching_en});
    cnt(80, 1, d);
    chk("blink_low", 8'h28, d);
    put(g | sb(S_VBUS_OV) | sb(S_BAT_OV), 0);
    cnt(20, 0, d);
    chk("irq_held", 8'h00, d);
    put(g, 8);
    rd(REG_FAULT, d);
    chk("fault_first", {2'h0, CF_INPUT, 4'h0}, d & 8'h30);
    rd(REG_FAULT, d);
    chk("fault_live", 8'h00, d);
    wr(REG_MASK, 8'h02);
    put(g | sb(S_VLIM), 0);
    cnt(20, 0, d);
    chk("vlim_masked", 8'h00, d);
    put(g | sb(S_VLIM) | sb(S_ILIM), 0);
    cnt(30, 0, d);
    chk("ilim_irq", 8'h10, d);
    wr(REG_CTRL0, 8'h77);
    put(g | sb(S_VBUS_OV), 8);
    cnt(60, 1, d);
    chk("stat_off", 8'h00, d);
    put(g | sb(S_BAT_SHORT), 8);
    chk("precharge", {6'h0, PRE_SHORT}, {6'h0, o_precharge_mode});
    put(g | sb(S_BAT_OCP), 4);
    put(g, 4);
    chk("ocp_latch", 8'h00, {7'h0, o_battery_switch_on});
    // A press shorter than the deglitch time must not release the latch.
    press(20);
    chk("short_press", 8'h00, {7'h0, o_battery_switch_on});
    press(40);
    chk("long_press", 8'h01, {7'h0, o_battery_switch_on});
    put(sb(S_BAT_DPL), 4);
    chk("depleted", 8'h00, {7'h0, o_battery_switch_on});
    put(g, 6);
    chk("input_back", 8'h01, {7'h0, o_battery_switch_on});
    wr(REG_CTRL1, 8'h20);
    put(g, 6);
    chk("boost_on", 8'h01, {7'h0, o_boost_en});
    put(g | sb(S_SYS_OV), 6);
    chk("boost_system_overvoltage", 8'h00, {7'h0, o_boost_en});
    put(g | sb(S_BST_OV), 6);
    chk("boost_ovp", 8'h00, {7'h0, o_boost_en});
    rd(REG_CTRL1, d);
    chk("boost_cfg", 8'h00, d & 8'h20);
    put('0, 2);
    i_reset_n <= 1'b0;
    repeat (2) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    repeat (2) @(posedge i_mclk);
    rd(REG_CTRL0, d);
    chk("reg00", 8'h17, d);
    rd(REG_CTRL1, d);
    chk("reg01", 8'h1a, d);
    rd(REG_TEMP, d);
    chk("reg06", 8'h01, d);
    rd(8'h0d, d);
    chk("unmapped", 8'h00, d);
    print_verdict;
  end
endmodule
